// >>> rtl/huf_flag.sv
/*
 * Head-unsafe flag logic: mode decode, fault selection, release-delay hold and the
 * open-drain drive of the shared flag line.
 * Assumes fault detector levels arrive asynchronously and the configuration fields
 * come from logic on core_clk; the shared line has an external pull-up.
 */
// How it works
// - Flag line only pulls low or releases
// - Sleep and standby release the line
// - Read with flag mode set: release
// - Read, flag mode clear: pull on faults
// - Main supply low is a fault input
// - Writer supply low is a fault input
// - Thermal asperity test pulls on detection
// - Analog test modes always release line
// - Servo write always pulls the line
// - Write with flag mode set: pull
// - Write, flag mode clear: release on faults
// - Write faults inhibit current unless inhibit bit set
// - Entering write masks detection during transient
// - Hold flag 0.5 to 1 us after fault
// - One shared detector, mode selects inputs
// - Power field: sleep, standby, active decode
// - Test field top bit selects asperity mode
// - Configuration resets to zero
`timescale 1ns/1ps

`include "huf_map.svh"

module huf_flag (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic [1:0]        power_ctrl,
    input  wire logic              write_select,
    input  wire logic [2:0]        test_mode,
    input  wire logic              servo_write_on,
    input  wire logic              flag_mode_bit,
    input  wire logic              write_inhibit_bit,
    input  wire logic              ref_res_fault,
    input  wire logic              vcc_low,
    input  wire logic              writer_supply_low,
    input  wire logic              write_data_slow,
    input  wire logic              write_head_fault,
    input  wire logic              unsel_head_biased,
    input  wire logic              thermal_asperity_detector,
    input  wire logic              head_unsafe_flag_in,
    output logic                   head_unsafe_flag_out,
    output logic                   head_unsafe_flag_oe,
    output logic                   write_current_inhibit,
    output logic                   unsafe_hold,
    output logic                   shared_line_low,
    output huf_pkg::huf_mode_type  active_mode
);
    import huf_pkg::*;

    localparam int HOLD_CYC = `HUF_HOLD_CYC;

    huf_state_type               st;
    huf_state_type               next_st;
    huf_mode_type                mode;
    logic [`HUF_NFAULT-1:0]      raw_fault;
    logic [`HUF_NFAULT-1:0]      mask;
    logic                        entering;
    logic                        hit;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    function automatic huf_mode_type huf_decode(input logic [1:0] pwr, input logic [2:0] tm,
                                                input logic servo, input logic wsel);
        huf_mode_type m;
        m = HUF_OFF;
        if (pwr != `HUF_PWR_ACTIVE) begin
            m = HUF_OFF;
        end else if (servo) begin
            m = HUF_SERVO;
        end else if (tm[`HUF_TM_TAS_BIT]) begin
            m = HUF_TAS;
        end else if (tm != `HUF_TM_NONE) begin
            m = HUF_ATEST;
        end else if (wsel) begin
            m = HUF_WRITE;
        end else begin
            m = HUF_READ;
        end
        return m;
    endfunction : huf_decode

    // Fault detector inputs in fixed bit order
    assign raw_fault = {thermal_asperity_detector, unsel_head_biased, write_head_fault,
                        write_data_slow, writer_supply_low, vcc_low, ref_res_fault};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        // Three-stage sync; a change counts once stages two and three agree
        next_st.sync1 = raw_fault;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.fault = (st.sync2 & st.sync3) | (st.fault & (st.sync2 | st.sync3));
        next_st.line_sync = {st.line_sync[1:0], ~head_unsafe_flag_in};
        next_st.line_low = (st.line_sync[1] & st.line_sync[2])
                         | (st.line_low & (st.line_sync[1] | st.line_sync[2]));
        // Configuration capture
        next_st.pwr = power_ctrl;
        next_st.tm = test_mode;
        next_st.servo = servo_write_on;
        next_st.wsel = write_select;
        next_st.flag_mode = flag_mode_bit;
        next_st.inhibit_cfg = write_inhibit_bit;
        mode = huf_decode(st.pwr, st.tm, st.servo, st.wsel);
        next_st.mode = mode;
        // Write entry blanking window
        entering = (mode == HUF_WRITE) && (st.mode != HUF_WRITE);
        if (entering) begin
            next_st.blank_cnt = `HUF_CNT_W'(`HUF_SETTLE_CYC);
        end else if (st.blank_cnt != '0) begin
            next_st.blank_cnt = st.blank_cnt - `HUF_CNT_W'(1);
        end
        // Mode picks which detector inputs count
        case (mode)
            HUF_READ:  mask = `HUF_MASK_READ;
            HUF_WRITE: mask = `HUF_MASK_WRITE;
            HUF_TAS:   mask = `HUF_MASK_TAS;
            default:   mask = '0;
        endcase
        hit = (|(st.fault & mask)) && !(entering || st.blank_cnt != '0);
        // Release-delay hold, restarted by every faulty cycle; a mode change clears it
        if (mode != st.mode) begin
            next_st.hold_cnt = '0;
        end else if (hit) begin
            next_st.hold_cnt = `HUF_CNT_W'(HOLD_CYC);
        end else if (st.hold_cnt != '0) begin
            next_st.hold_cnt = st.hold_cnt - `HUF_CNT_W'(1);
        end
        next_st.unsafe = (next_st.hold_cnt != '0);
        // Line drive per mode
        case (mode)
            HUF_OFF:   next_st.oe = 1'b0;
            HUF_SERVO: next_st.oe = 1'b1;
            HUF_TAS:   next_st.oe = next_st.unsafe;
            HUF_ATEST: next_st.oe = 1'b0;
            HUF_READ:  next_st.oe = !st.flag_mode && next_st.unsafe;
            HUF_WRITE: next_st.oe = st.flag_mode || !next_st.unsafe;
            default:   next_st.oe = 1'b0;
        endcase
        next_st.inhibit = (mode == HUF_WRITE) && !st.inhibit_cfg && next_st.unsafe;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.mode <= HUF_OFF;
        end else begin
            st <= next_st;
        end
    end

    // Outputs; the pin value is always low, only the enable moves
    assign head_unsafe_flag_out = 1'b0;
    assign head_unsafe_flag_oe = st.oe;
    assign write_current_inhibit = st.inhibit;
    assign unsafe_hold = st.unsafe;
    assign shared_line_low = st.line_low;
    assign active_mode = st.mode;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic [`HUF_CNT_W-1:0] quiet_cnt;

    // Cycles since the last faulty cycle or mode change, saturating
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_cnt <= '0;
        end else if (hit || mode != st.mode) begin
            quiet_cnt <= '0;
        end else if (quiet_cnt != '1) begin
            quiet_cnt <= quiet_cnt + `HUF_CNT_W'(1);
        end
    end

    sequence read_fault_s;
        mode == HUF_READ && !st.flag_mode && hit;
    endsequence

    sequence write_fault_s;
        mode == HUF_WRITE && !st.flag_mode && hit;
    endsequence

    idle_release_a: assert property (st.mode == HUF_OFF |-> !head_unsafe_flag_oe)
        else $error("line pulled in sleep or standby");
    servo_pull_a: assert property (st.mode == HUF_SERVO |-> head_unsafe_flag_oe)
        else $error("line released in servo write");
    read_forced_a: assert property (st.mode == HUF_READ && $past(st.flag_mode) |-> !st.oe)
        else $error("read with flag mode set pulled line");
    read_fault_a: assert property (read_fault_s |=> head_unsafe_flag_oe[*3])
        else $error("read fault did not pull line");
    atest_release_a: assert property (st.mode == HUF_ATEST |-> !head_unsafe_flag_oe)
        else $error("analog test pulled line");
    write_forced_a: assert property (st.mode == HUF_WRITE && $past(st.flag_mode) |-> st.oe)
        else $error("write with flag mode set released line");
    write_fault_a: assert property (write_fault_s |=> !head_unsafe_flag_oe)
        else $error("write fault did not release line");
    tas_flag_a: assert property (mode == HUF_TAS && hit |=> head_unsafe_flag_oe)
        else $error("asperity not flagged");
    // A mode change also clears the hold; only a countdown release is timed
    hold_time_a: assert property ($fell(unsafe_hold) && !$past(mode != st.mode)
                                  |-> quiet_cnt == HOLD_CYC)
        else $error("hold released at wrong time");
    inhibit_a: assert property (write_current_inhibit |-> st.mode == HUF_WRITE
                                && unsafe_hold && !$past(st.inhibit_cfg))
        else $error("write inhibit without cause");

endmodule : huf_flag

// >>> rtl/huf_map.svh
/*
 * Constants for the head-unsafe flag logic: timing, mode codes, fault bit positions.
 * Assumes a 40 MHz core clock; included by the package and by the flag module.
 */
`ifndef HUF_MAP_SVH
`define HUF_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define HUF_CLK_NS      25
`define HUF_HOLD_NS     500
`define HUF_HOLD_MAX_NS 1000
`define HUF_HOLD_CYC    (((`HUF_HOLD_NS) + (`HUF_CLK_NS) - 1) / (`HUF_CLK_NS))
`define HUF_SETTLE_NS   15
`define HUF_SETTLE_CYC  (((`HUF_SETTLE_NS) + (`HUF_CLK_NS) - 1) / (`HUF_CLK_NS))
`define HUF_CNT_W       6

// ----------------------------------------
// Mode field codes
// ----------------------------------------
`define HUF_PWR_SLEEP   2'h0
`define HUF_PWR_ACTIVE  2'h3
`define HUF_TM_NONE     3'h0
`define HUF_TM_TAS_BIT  2

// ----------------------------------------
// Fault vector layout and per-mode masks
// ----------------------------------------
`define HUF_NFAULT      7
`define HUF_F_REF       0
`define HUF_F_VCC       1
`define HUF_F_WSUP      2
`define HUF_F_WDATA     3
`define HUF_F_HEAD      4
`define HUF_F_UNSEL     5
`define HUF_F_TAS       6
`define HUF_MASK_READ   7'h07
`define HUF_MASK_WRITE  7'h3F
`define HUF_MASK_TAS    7'h40

`endif

// >>> rtl/huf_pkg.sv
/*
 * Types for the head-unsafe flag logic: operating mode and the packed state.
 * Assumes huf_map.svh is on the include path.
 */
`include "huf_map.svh"

package huf_pkg;

    // Operating mode, one-hot
    typedef enum logic [5:0] {
        HUF_OFF   = 6'h01,
        HUF_SERVO = 6'h02,
        HUF_TAS   = 6'h04,
        HUF_ATEST = 6'h08,
        HUF_READ  = 6'h10,
        HUF_WRITE = 6'h20
    } huf_mode_type;

    // Register state of the block, all but the assertion counter quiet_cnt
    typedef struct packed {
        logic [`HUF_NFAULT-1:0] sync1;
        logic [`HUF_NFAULT-1:0] sync2;
        logic [`HUF_NFAULT-1:0] sync3;
        logic [`HUF_NFAULT-1:0] fault;
        logic [2:0]             line_sync;
        logic                   line_low;
        logic [1:0]             pwr;
        logic [2:0]             tm;
        logic                   servo;
        logic                   wsel;
        logic                   flag_mode;
        logic                   inhibit_cfg;
        huf_mode_type           mode;
        logic [`HUF_CNT_W-1:0]  blank_cnt;
        logic [`HUF_CNT_W-1:0]  hold_cnt;
        logic                   unsafe;
        logic                   oe;
        logic                   inhibit;
    } huf_state_type;

endpackage : huf_pkg

// >>> testbench/huf_ctrl_model.sv
/*
 * Drive controller side of the shared head-unsafe wire: pull-up plus a
 * second amplifier that may pull the wire low.
 * Assumes the device pin is open drain, driven by data and output enable.
 */
`timescale 1ns/1ps

module huf_ctrl_model (
    input  wire logic dev_oe,
    input  wire logic dev_out,
    input  wire logic other_oe,
    output logic      line_high
);
    // ----------------------------------------
    // Wired line
    // ----------------------------------------
    // Pull-up wins unless some amplifier pulls low
    assign line_high = !((dev_oe && !dev_out) || other_oe);
endmodule : huf_ctrl_model

// >>> testbench/tb_head_unsafe_fault_flag.sv
/*
 * Self-checking bench for the head-unsafe flag logic: mode table, hold
 * timing, write entry, inhibit, shared wire and reset.
 * Assumes huf_pkg and huf_flag are compiled first.
 */
`timescale 1ns/1ps

module tb_head_unsafe_fault_flag;
    import huf_pkg::*;
    typedef struct packed {
        logic [1:0] p; logic w; logic [2:0] t; logic s; logic m;
        logic [6:0] f; huf_mode_type md; logic o0; logic o1;
    } huf_row_type;
    logic         core_clk, sys_rst, ws, sv, fm, wib, oth, line_high;
    logic [1:0]   pwr;
    logic [2:0]   tm;
    logic [6:0]   flt;
    logic         hout, hoe, winh, uhold, slow;
    huf_mode_type amode;
    int           err_count, checked, n;
    // Config, fault pattern, expected mode, idle oe, faulted oe
    huf_row_type rows [21] = '{
        '{2'h0,1'h0,3'h0,1'h0,1'h0,7'h01,HUF_OFF,1'h0,1'h0},
        '{2'h1,1'h0,3'h0,1'h0,1'h0,7'h01,HUF_OFF,1'h0,1'h0},
        '{2'h2,1'h1,3'h0,1'h0,1'h0,7'h01,HUF_OFF,1'h0,1'h0},
        '{2'h3,1'h0,3'h0,1'h0,1'h0,7'h01,HUF_READ,1'h0,1'h1},
        '{2'h3,1'h0,3'h0,1'h0,1'h0,7'h02,HUF_READ,1'h0,1'h1},
        '{2'h3,1'h0,3'h0,1'h0,1'h0,7'h04,HUF_READ,1'h0,1'h1},
        '{2'h3,1'h0,3'h0,1'h0,1'h1,7'h01,HUF_READ,1'h0,1'h0},
        '{2'h3,1'h0,3'h0,1'h0,1'h0,7'h08,HUF_READ,1'h0,1'h0},
        '{2'h3,1'h1,3'h0,1'h0,1'h0,7'h01,HUF_WRITE,1'h1,1'h0},
        '{2'h3,1'h1,3'h0,1'h0,1'h0,7'h08,HUF_WRITE,1'h1,1'h0},
        '{2'h3,1'h1,3'h0,1'h0,1'h0,7'h10,HUF_WRITE,1'h1,1'h0},
        '{2'h3,1'h1,3'h0,1'h0,1'h0,7'h20,HUF_WRITE,1'h1,1'h0},
        '{2'h3,1'h1,3'h0,1'h0,1'h0,7'h02,HUF_WRITE,1'h1,1'h0},
        '{2'h3,1'h1,3'h0,1'h0,1'h1,7'h01,HUF_WRITE,1'h1,1'h1},
        '{2'h3,1'h1,3'h0,1'h0,1'h0,7'h40,HUF_WRITE,1'h1,1'h1},
        '{2'h3,1'h0,3'h4,1'h0,1'h0,7'h40,HUF_TAS,1'h0,1'h1},
        '{2'h3,1'h0,3'h5,1'h0,1'h1,7'h40,HUF_TAS,1'h0,1'h1},
        '{2'h3,1'h0,3'h6,1'h0,1'h0,7'h01,HUF_TAS,1'h0,1'h0},
        '{2'h3,1'h0,3'h1,1'h0,1'h0,7'h01,HUF_ATEST,1'h0,1'h0},
        '{2'h3,1'h1,3'h3,1'h0,1'h1,7'h01,HUF_ATEST,1'h0,1'h0},
        '{2'h3,1'h1,3'h2,1'h1,1'h0,7'h01,HUF_SERVO,1'h1,1'h1}
    };

    huf_flag i_huf_flag (
        .core_clk(core_clk), .sys_rst(sys_rst), .power_ctrl(pwr),
        .write_select(ws), .test_mode(tm), .servo_write_on(sv),
        .flag_mode_bit(fm), .write_inhibit_bit(wib), .ref_res_fault(flt[0]),
        .vcc_low(flt[1]), .writer_supply_low(flt[2]), .write_data_slow(flt[3]),
        .write_head_fault(flt[4]), .unsel_head_biased(flt[5]),
        .thermal_asperity_detector(flt[6]), .head_unsafe_flag_in(line_high),
        .head_unsafe_flag_out(hout), .head_unsafe_flag_oe(hoe),
        .write_current_inhibit(winh), .unsafe_hold(uhold),
        .shared_line_low(slow), .active_mode(amode)
    );
    huf_ctrl_model i_huf_ctrl_model (
        .dev_oe(hoe), .dev_out(hout), .other_oe(oth), .line_high(line_high)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input string nm, input logic [5:0] e, input logic [5:0] g);
        checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk
    task cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc
    task summarize;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // Clock and watchdog
    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        summarize();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {pwr, ws, tm, sv, fm, wib, flt, oth} = '0;
        sys_rst = 1'h1;
        cyc(1);
        chk("oe_rst", 6'h00, {5'h00, hoe});
        chk("mode_rst", HUF_OFF, amode);
        $display("test reset done");
        cyc(4);
        sys_rst = 1'h0;
        foreach (rows[i]) begin
            {pwr, ws, tm, sv, fm} = {rows[i].p, rows[i].w, rows[i].t, rows[i].s, rows[i].m};
            cyc(4);
            chk("mode", rows[i].md, amode);
            chk("oe_idle", {5'h00, rows[i].o0}, {5'h00, hoe});
            chk("out", 6'h00, {5'h00, hout});
            flt = rows[i].f;
            cyc(6);
            chk("oe_fault", {5'h00, rows[i].o1}, {5'h00, hoe});
            flt = '0;
            cyc(30);
            $display("row %0d done", i);
        end
        // Hold restarts on a second burst, then lasts 20..40 cycles
        {pwr, ws, tm, sv, fm} = 8'h c0;
        cyc(4);
        flt = 7'h01;
        cyc(4);
        flt = '0;
        cyc(10);
        chk("hold_mid", 6'h01, {5'h00, hoe});
        chk("hold_flag", 6'h01, {5'h00, uhold});
        flt = 7'h01;
        cyc(4);
        flt = '0;
        n = 0;
        while (hoe === 1'h1 && n < 60) begin
            cyc(1);
            n++;
        end
        chk("hold_min", 6'h01, {5'h00, n >= 20});
        chk("hold_max", 6'h01, {5'h00, n <= 40});
        $display("test hold done");
        // Write entry with a fault present, then inhibit
        flt = 7'h10;
        cyc(4);
        ws = 1'h1;
        cyc(3);
        chk("oe_entry", 6'h01, {5'h00, hoe});
        cyc(5);
        chk("oe_head", 6'h00, {5'h00, hoe});
        chk("inh_on", 6'h01, {5'h00, winh});
        wib = 1'h1;
        flt = 7'h02;
        cyc(6);
        chk("inh_off", 6'h00, {5'h00, winh});
        chk("oe_vcc", 6'h00, {5'h00, hoe});
        sys_rst = 1'h1;
        cyc(1);
        chk("oe_rst2", 6'h00, {5'h00, hoe});
        chk("uh_rst2", 6'h00, {5'h00, uhold});
        sys_rst = 1'h0;
        flt = '0;
        $display("test write done");
        // Another amplifier pulls the shared wire while asleep
        pwr = 2'h0;
        cyc(4);
        oth = 1'h1;
        cyc(6);
        chk("sense_low", 6'h01, {5'h00, slow});
        oth = 1'h0;
        cyc(6);
        chk("sense_high", 6'h00, {5'h00, slow});
        chk("wire_high", 6'h01, {5'h00, line_high});
        $display("test wire done");
        summarize();
    end
endmodule : tb_head_unsafe_fault_flag
